// [bench/dma_irq_mask_and_clear_tb_top.sv]
// Self-checking testbench for the DMA interrupt mask and clear block
`timescale 1ns/100ps
module dma_irq_mask_and_clear_tb_top;
  localparam logic [2:0][11:0] MOFS = {dimc_pkg::FLT_MASK_LO_OFS, dimc_pkg::DST_MASK_LO_OFS,
                                       dimc_pkg::SRC_MASK_LO_OFS};
  localparam logic [11:0] CLR  = dimc_pkg::XFER_CLR_LO_OFS;
  localparam logic [11:0] COMB = dimc_pkg::COMB_STAT_LO_OFS;
  logic        clock  = 1'b0;
  logic        rst    = 1'b1;
  logic        hsel   = 1'b0;
  logic [11:0] haddr  = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [2:0]  evt    = 3'h0;
  logic [2:0][2:0] st = '0;
  logic [1:0]  ttype  = dimc_pkg::HTRANS_NONSEQ;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        rsp;
  logic [2:0]  xfer_st;
  wire  [2:0][2:0] mask_v;
  wire  [2:0]  irq_v;
  logic        xfer_irq;
  int          num_errors = 0;
  int          n_checks = 0;

  always #2.5 clock = ~clock;

  dimc_irq_mask dut_u (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(1'b1), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .xfer_done_evt(evt), .src_done_status(st[0]), .dst_done_status(st[1]),
    .fault_status_bits(st[2]), .xfer_done_status(xfer_st), .src_done_mask(mask_v[0]),
    .dst_done_mask(mask_v[1]), .fault_mask(mask_v[2]), .src_done_irq(irq_v[0]),
    .dst_done_irq(irq_v[1]), .fault_irq(irq_v[2]), .xfer_done_irq(xfer_irq)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One zero-wait transfer: address phase, then data phase
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    #1;
    hsel = 1'b1;
    htrans = ttype;
    hwrite = w;
    haddr = a;
    @(posedge clock);
    #1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwdata = d;
    for (int n = 0; hreadyout !== 1'b1; n++) begin
      if (n == 8) begin
        num_errors++;
        print_verdict();
      end
      @(posedge clock);
      #1;
    end
    rd = hrdata;
    rsp = hresp;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(rd, exp);
  endtask

  initial begin
    repeat (20) @(posedge clock);
    #1;
    rst = 1'b0;
    for (int a = 0; a < 8; a++) rdchk(12'h320 + 12'(4 * a), 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      wr(MOFS[i], 32'h0000_0107);
      rdchk(MOFS[i], 32'h0000_0001);
      wr(MOFS[i], 32'h0000_0606);
      rdchk(MOFS[i], 32'h0000_0007);
      wr(MOFS[i], 32'hFFFF_F8F8);
      rdchk(MOFS[i], 32'h0000_0007);
      wr(MOFS[i], 32'hFFFF_F9FA);
      rdchk(MOFS[i], 32'h0000_0006);
      chk(32'(mask_v[i]), 32'h0000_0006);
      st[i] = 3'h1;
      @(posedge clock);
      #1;
      chk(32'(irq_v[i]), 32'h0000_0000);
      st[i] = 3'h2;
      @(posedge clock);
      #1;
      chk(32'(irq_v[i]), 32'h0000_0001);
      st[i] = 3'h0;
    end
    // Sequential transfer type, decoded like a non-sequential one
    ttype = dimc_pkg::HTRANS_SEQ;
    for (int a = 1; a < 8; a += 2) begin
      wr(12'h320 + 12'(4 * a), 32'hFFFF_FFFF);
      rdchk(12'h320 + 12'(4 * a), 32'h0000_0000);
    end
    ttype = dimc_pkg::HTRANS_NONSEQ;
    for (int i = 0; i < 3; i++) rdchk(MOFS[i], 32'h0000_0006);
    st[0] = 3'h4;
    st[1] = 3'h1;
    st[2] = 3'h2;
    rdchk(COMB, 32'h0000_001C);
    @(posedge clock);
    #1;
    evt = 3'h5;
    @(posedge clock);
    #1;
    evt = 3'h0;
    chk(32'(xfer_st), 32'h0000_0005);
    chk(32'(xfer_irq), 32'h0000_0001);
    rdchk(COMB, 32'h0000_001D);
    wr(CLR, 32'hFFFF_FFFA);
    rdchk(CLR, 32'h0000_0000);
    chk(32'(xfer_st), 32'h0000_0005);
    // Event in the clear's data phase: the set wins
    wr(CLR, 32'h0000_0001);
    evt = 3'h1;
    @(posedge clock);
    #1;
    evt = 3'h0;
    chk(32'(xfer_st), 32'h0000_0005);
    wr(CLR, 32'h0000_0001);
    rdchk(CLR, 32'h0000_0000);
    chk(32'(xfer_st), 32'h0000_0004);
    wr(CLR, 32'h0000_0004);
    rdchk(COMB, 32'h0000_001C);
    chk(32'(xfer_irq), 32'h0000_0000);
    rdchk(12'h3F0, 32'h0000_0000);
    chk(32'(rsp), 32'h0000_0000);
    rst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 3; i++) chk(32'(mask_v[i]), 32'h0000_0000);
    for (int i = 0; i < 3; i++) rdchk(MOFS[i], 32'h0000_0000);
    print_verdict();
  end
endmodule // dma_irq_mask_and_clear_tb_top

// [logic/dimc_irq_mask.sv]
// DMA interrupt masks, transfer-complete clear and combined status over AHB-Lite
//
// Function
// - Mask registers carry three write-enable bits
// - Source-done mask: three bits, 1 passes
// - Destination-done mask: same polarity and gating
// - Fault mask: three bits, enables above
// - All masks reset to zero
// - Clear register acts on transfer-complete status
// - Reserved bits read zero, ignore writes
// - Combined status ORs each type's bits
`timescale 1ns/100ps
module dimc_irq_mask #(
  parameter int unsigned CH = dimc_pkg::NUM_CH
) (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          hsel,
  input  wire logic [11:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire logic [CH-1:0] xfer_done_evt,
  input  wire logic [CH-1:0] src_done_status,
  input  wire logic [CH-1:0] dst_done_status,
  input  wire logic [CH-1:0] fault_status_bits,
  output logic      [CH-1:0] xfer_done_status,
  output logic      [CH-1:0] src_done_mask,
  output logic      [CH-1:0] dst_done_mask,
  output logic      [CH-1:0] fault_mask,
  output logic               src_done_irq,
  output logic               dst_done_irq,
  output logic               fault_irq,
  output logic               xfer_done_irq
);
  logic          addr_ph;
  logic          wr_ph_d;
  logic          wr_ph_q;
  logic [11:0]   waddr_d;
  logic [11:0]   waddr_q;
  logic [CH-1:0] src_mask_d;
  logic [CH-1:0] dst_mask_d;
  logic [CH-1:0] flt_mask_d;
  logic [CH-1:0] xfer_st_d;
  logic [CH-1:0] xfer_st_q;
  logic [CH-1:0] clr_bits;
  logic [31:0]   rdata_d;
  logic [31:0]   rdata_q;
  logic          wr_src;
  logic          wr_dst;
  logic          wr_flt;
  logic          wr_clr;

  assign addr_ph = hsel && hready &&
                   (htrans == dimc_pkg::HTRANS_NONSEQ || htrans == dimc_pkg::HTRANS_SEQ);

  // Write data arrives one cycle after its address
  always_comb begin
    wr_ph_d = addr_ph && hwrite;
    waddr_d = addr_ph ? haddr : waddr_q;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ph_q <= 1'b0;
      waddr_q <= 12'h000;
    end else begin
      wr_ph_q <= wr_ph_d;
      waddr_q <= waddr_d;
    end
  end

  assign wr_src = wr_ph_q && (waddr_q == dimc_pkg::SRC_MASK_LO_OFS);
  assign wr_dst = wr_ph_q && (waddr_q == dimc_pkg::DST_MASK_LO_OFS);
  assign wr_flt = wr_ph_q && (waddr_q == dimc_pkg::FLT_MASK_LO_OFS);
  assign wr_clr = wr_ph_q && (waddr_q == dimc_pkg::XFER_CLR_LO_OFS);

  dimc_mask_reg #(.CH(CH)) u_src_mask (
    .clock      (clock),
    .rst        (rst),
    .wr_hit     (wr_src),
    .wr_mask    (hwdata[dimc_pkg::MASK_LSB +: CH]),
    .wr_en_bits (hwdata[dimc_pkg::MASK_WE_LSB +: CH]),
    .mask_d     (src_mask_d),
    .mask_q     (src_done_mask)
  );

  dimc_mask_reg #(.CH(CH)) u_dst_mask (
    .clock      (clock),
    .rst        (rst),
    .wr_hit     (wr_dst),
    .wr_mask    (hwdata[dimc_pkg::MASK_LSB +: CH]),
    .wr_en_bits (hwdata[dimc_pkg::MASK_WE_LSB +: CH]),
    .mask_d     (dst_mask_d),
    .mask_q     (dst_done_mask)
  );

  dimc_mask_reg #(.CH(CH)) u_flt_mask (
    .clock      (clock),
    .rst        (rst),
    .wr_hit     (wr_flt),
    .wr_mask    (hwdata[dimc_pkg::MASK_LSB +: CH]),
    .wr_en_bits (hwdata[dimc_pkg::MASK_WE_LSB +: CH]),
    .mask_d     (flt_mask_d),
    .mask_q     (fault_mask)
  );

  assign clr_bits = wr_clr ? hwdata[CH-1:0] : '0;

  always_comb begin
    xfer_st_d = (xfer_st_q & ~clr_bits) | xfer_done_evt;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      xfer_st_q <= dimc_pkg::STATUS_RESET;
    end else begin
      xfer_st_q <= xfer_st_d;
    end
  end

  assign xfer_done_status = xfer_st_q;

  // Read data from next-state values so a write just before reads back
  always_comb begin
    rdata_d = dimc_pkg::WORD_ZERO;
    if (addr_ph && !hwrite) begin
      case (haddr)
        dimc_pkg::SRC_MASK_LO_OFS: begin
          rdata_d[CH-1:0] = src_mask_d;
        end
        dimc_pkg::DST_MASK_LO_OFS: begin
          rdata_d[CH-1:0] = dst_mask_d;
        end
        dimc_pkg::FLT_MASK_LO_OFS: begin
          rdata_d[CH-1:0] = flt_mask_d;
        end
        dimc_pkg::COMB_STAT_LO_OFS: begin
          rdata_d[dimc_pkg::COMB_XFER_BIT]  = |xfer_st_d;
          rdata_d[dimc_pkg::COMB_SRC_BIT]   = |src_done_status;
          rdata_d[dimc_pkg::COMB_DST_BIT]   = |dst_done_status;
          rdata_d[dimc_pkg::COMB_FAULT_BIT] = |fault_status_bits;
        end
        default: begin
          rdata_d = dimc_pkg::WORD_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= dimc_pkg::WORD_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = dimc_pkg::HRESP_OKAY;

  assign src_done_irq  = |(src_done_status & src_done_mask);
  assign dst_done_irq  = |(dst_done_status & dst_done_mask);
  assign fault_irq     = |(fault_status_bits & fault_mask);
  assign xfer_done_irq = |xfer_st_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence src_wr_s;
    wr_src ##0 !hwdata[dimc_pkg::MASK_WE_LSB];
  endsequence

  mask_hold_a: assert property (src_wr_s |=> $stable(src_done_mask[0]))
    else $error("source mask bit changed without its enable");
  mask_set_a: assert property (wr_dst && hwdata[dimc_pkg::MASK_WE_LSB + 1]
                               |=> dst_done_mask[1] == $past(hwdata[1]))
    else $error("destination mask bit not written with enable");
  mask_reset_a: assert property ($past(rst) |-> src_done_mask == '0
                                 && dst_done_mask == '0 && fault_mask == '0)
    else $error("mask not zero after reset");
  status_clear_a: assert property (wr_clr && hwdata[0] && !xfer_done_evt[0]
                                   |=> !xfer_done_status[0])
    else $error("transfer-complete status not cleared");
  set_wins_a: assert property (xfer_done_evt[2] |=> xfer_done_status[2])
    else $error("transfer-complete event lost");
  fault_read_a: assert property (addr_ph && !hwrite
                                 && haddr == dimc_pkg::FLT_MASK_LO_OFS
                                 ##1 !wr_ph_q |-> hrdata == {29'h0, fault_mask})
    else $error("fault mask readback wrong");
  rsvd_read_a: assert property (addr_ph && !hwrite
                                && haddr == dimc_pkg::SRC_MASK_HI_OFS |=> hrdata == '0)
    else $error("reserved register not zero");
  comb_read_a: assert property (addr_ph && !hwrite
                                && haddr == dimc_pkg::COMB_STAT_LO_OFS
                                |=> hrdata[4] == ($past(fault_status_bits) != '0))
    else $error("combined fault summary wrong");
  fault_irq_a: assert property (fault_status_bits[0] && !fault_mask[0]
                                && fault_status_bits[2:1] == '0 |-> !fault_irq)
    else $error("fault interrupt while masked");
  fault_pass_a: assert property (fault_status_bits[1] && fault_mask[1] |-> fault_irq)
    else $error("unmasked fault interrupt missing");
  clear_race_a: assert property (wr_clr && hwdata[0] && xfer_done_evt[0]
                                 |=> xfer_done_status[0])
    else $error("transfer-complete event lost to clear");
  rsvd_write_a: assert property (wr_ph_q && waddr_q == dimc_pkg::SRC_MASK_HI_OFS
                                 |=> $stable(src_done_mask))
    else $error("reserved register write changed a mask");
endmodule // dimc_irq_mask

// [logic/dimc_mask_reg.sv]
// Mask register with per-channel write enables
`timescale 1ns/100ps
module dimc_mask_reg #(
  parameter int unsigned CH = 3
) (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          wr_hit,
  input  wire logic [CH-1:0] wr_mask,
  input  wire logic [CH-1:0] wr_en_bits,
  output logic      [CH-1:0] mask_d,
  output logic      [CH-1:0] mask_q
);
  always_comb begin
    mask_d = mask_q;
    if (wr_hit) begin
      mask_d = (mask_q & ~wr_en_bits) | (wr_mask & wr_en_bits);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mask_q <= CH'(dimc_pkg::MASK_RESET);
    end else begin
      mask_q <= mask_d;
    end
  end
endmodule // dimc_mask_reg

// [logic/dimc_pkg.sv]
// Package: register map, fields and reset values of the DMA interrupt mask block
package dimc_pkg;
  localparam int unsigned NUM_CH = 3;
  localparam logic [11:0] SRC_MASK_LO_OFS  = 12'h320;
  localparam logic [11:0] SRC_MASK_HI_OFS  = 12'h324;
  localparam logic [11:0] DST_MASK_LO_OFS  = 12'h328;
  localparam logic [11:0] DST_MASK_HI_OFS  = 12'h32C;
  localparam logic [11:0] FLT_MASK_LO_OFS  = 12'h330;
  localparam logic [11:0] FLT_MASK_HI_OFS  = 12'h334;
  localparam logic [11:0] XFER_CLR_LO_OFS  = 12'h338;
  localparam logic [11:0] XFER_CLR_HI_OFS  = 12'h33C;
  localparam logic [11:0] COMB_STAT_LO_OFS = 12'h360;
  localparam logic [11:0] COMB_STAT_HI_OFS = 12'h364;
  localparam int unsigned MASK_LSB    = 0;
  localparam int unsigned MASK_WE_LSB = 8;
  localparam int unsigned COMB_XFER_BIT  = 0;
  localparam int unsigned COMB_SRC_BIT   = 2;
  localparam int unsigned COMB_DST_BIT   = 3;
  localparam int unsigned COMB_FAULT_BIT = 4;
  localparam logic [2:0]  MASK_RESET   = 3'h0;
  localparam logic [2:0]  STATUS_RESET = 3'h0;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
  localparam logic        HRESP_OKAY    = 1'h0;
endpackage
